/* rtl/usb_attach_pkg.sv */
// constants, register map and types for the usb attach and detach control block
package usb_attach_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int LINE_N = 8;   // lines 9 down to 2, index 0 is line 2
    localparam int LINE_W = 3;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_CFG    = 12'h004;
    localparam logic [11:0] OFS_PULL   = 12'h008;
    localparam logic [11:0] OFS_GPIO   = 12'h00C;
    localparam logic [11:0] OFS_STATUS = 12'h010;
    localparam logic [11:0] OFS_POWER  = 12'h014;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTRL_READY_BIT    = 0;
    localparam int CTRL_EXTPU_BIT    = 1;
    localparam int CTRL_SELFPWR_BIT  = 2;
    localparam int CTRL_WAKE_BIT     = 3;
    localparam int CFG_SENSE_LSB     = 0;
    localparam int CFG_DETACH_LSB    = 4;
    localparam int CFG_WAKE_LSB      = 8;
    localparam int CFG_PU_LSB        = 12;
    localparam int CFG_DETACH_EN_BIT = 16;
    localparam int CFG_WAKE_EN_BIT   = 17;
    localparam int PULL_UP_LSB       = 0;
    localparam int PULL_DN_LSB       = 8;
    localparam int PULL_STRONG_LSB   = 16;
    localparam int GPIO_OE_LSB       = 8;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [2:0]  CTRL_RST  = 3'h4;         // self powered, not ready
    localparam logic [17:0] CFG_RST   = 18'h0_0000;   // sense on index 0, line 2
    localparam logic [23:0] PULL_RST  = 24'h00_FF00;  // weak pull-down on all
    localparam logic [15:0] GPIO_RST  = 16'h0000;     // all inputs
    localparam logic [7:0]  POWER_RST = 8'h32;
    localparam logic        FULL_SPEED_ONLY = 1'b1;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        LINK_OFF,
        LINK_ON,
        LINK_DETACHED
    } link_state_t;

endpackage : usb_attach_pkg

/* rtl/prog_io_sync.sv */
// two-flop synchroniser for the programmable line inputs
`timescale 1ns/1ps
module prog_io_sync
    import usb_attach_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic [LINE_N-1:0] async_in,
    output logic      [LINE_N-1:0] sync_out
);

    logic [LINE_N-1:0] meta;

    // first stage is read by the second stage only
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : prog_io_sync

/* rtl/prog_io_pad.sv */
// per-line output, enable and pull control for the programmable lines
`timescale 1ns/1ps
module prog_io_pad
    import usb_attach_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic [LINE_N-1:0] gpio_out,
    input  wire logic [LINE_N-1:0] gpio_oe,
    input  wire logic [LINE_N-1:0] ovr_mask,
    input  wire logic [LINE_N-1:0] ovr_oe,
    input  wire logic [LINE_N-1:0] ovr_val,
    input  wire logic [LINE_N-1:0] pull_up,
    input  wire logic [LINE_N-1:0] pull_dn,
    input  wire logic [LINE_N-1:0] pull_strong,
    output logic      [LINE_N-1:0] pin_out,
    output logic      [LINE_N-1:0] pin_oe,
    output logic      [LINE_N-1:0] pin_pu,
    output logic      [LINE_N-1:0] pin_pd,
    output logic      [LINE_N-1:0] pin_strong
);

    // block functions win over plain software outputs on their line
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else begin
            pin_out <= (ovr_mask & ovr_val) | (~ovr_mask & gpio_out);
            pin_oe  <= (ovr_mask & ovr_oe) | (~ovr_mask & gpio_oe);
        end
    end

    // pulls follow configuration; pull-up wins if both are set
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pin_pu     <= '0;
            pin_pd     <= '1;
            pin_strong <= '0;
        end else begin
            pin_pu     <= pull_up;
            pin_pd     <= pull_dn & ~pull_up;
            pin_strong <= pull_strong;
        end
    end

endmodule : prog_io_pad

/* rtl/usb_attach_detach_control.sv */
// top of the usb attach, detach and host-wake control block with its apb registers
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
module usb_attach_detach_control
    import usb_attach_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [LINE_N-1:0] prog_io_line_in,
    output logic      [LINE_N-1:0] prog_io_line_out,
    output logic      [LINE_N-1:0] prog_io_line_oe,
    output logic      [LINE_N-1:0] prog_io_line_pu,
    output logic      [LINE_N-1:0] prog_io_line_pd,
    output logic      [LINE_N-1:0] prog_io_line_strong,
    input  wire logic              dplus_pin_in,
    output logic                   dplus_pin_out,
    output logic                   dplus_pin_oe,
    input  wire logic              dminus_pin_in,
    output logic                   dminus_pin_out,
    output logic                   dminus_pin_oe,
    output logic                   dplus_pullup_en,
    input  wire logic              core_tx_dp,
    input  wire logic              core_tx_dm,
    input  wire logic              core_tx_oe,
    output logic                   core_rx_dp,
    output logic                   core_rx_dm,
    input  wire logic              core_resume_req,
    output logic                   core_resume_ok,
    output logic                   core_connected,
    output logic                   core_reconnect,
    output logic                   core_bus_powered,
    output logic      [7:0]        core_max_power,
    output logic                   core_full_speed
);

    // ************************************************************
    // helper functions
    // ************************************************************

    // pick one line out of the synchronised vector
    function automatic logic line_pick(input logic [LINE_N-1:0] v,
                                       input logic [LINE_W-1:0] idx);
        return v[idx];
    endfunction : line_pick

    // one-hot mask for a selected line
    function automatic logic [LINE_N-1:0] line_hot(input logic [LINE_W-1:0] idx);
        logic [LINE_N-1:0] m;
        m      = '0;
        m[idx] = 1'b1;
        return m;
    endfunction : line_hot

    function automatic logic addr_known(input logic [11:0] a);
        return (a == OFS_CTRL) || (a == OFS_CFG) || (a == OFS_PULL) ||
               (a == OFS_GPIO) || (a == OFS_STATUS) || (a == OFS_POWER);
    endfunction : addr_known

    // ************************************************************
    // registers and apb slave
    // ************************************************************
    logic [2:0]        ctrl_reg;
    logic [17:0]       cfg_reg;
    logic [23:0]       pull_reg;
    logic [15:0]       gpio_reg;
    logic [7:0]        power_reg;
    logic              wr_acc;
    logic              sw_wake;
    logic [LINE_N-1:0] io_sync;
    logic              sense;
    logic              detach;
    logic              wake_pend;
    link_state_t       state;
    link_state_t       next_state;
    logic              pullup_on;
    logic              ext_drive;

    // zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_known(paddr);
    assign wr_acc  = psel & penable & pwrite & addr_known(paddr);
    assign sw_wake = wr_acc & (paddr == OFS_CTRL) & pwdata[CTRL_WAKE_BIT];

    // software-written configuration
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ctrl_reg  <= CTRL_RST;
            cfg_reg   <= CFG_RST;
            pull_reg  <= PULL_RST;
            gpio_reg  <= GPIO_RST;
            power_reg <= POWER_RST;
        end else if (wr_acc) begin
            case (paddr)
                OFS_CTRL:  ctrl_reg  <= pwdata[2:0];
                OFS_CFG:   cfg_reg   <= pwdata[17:0];
                OFS_PULL:  pull_reg  <= pwdata[23:0];
                OFS_GPIO:  gpio_reg  <= pwdata[15:0];
                OFS_POWER: power_reg <= pwdata[7:0];
                default:   ctrl_reg  <= ctrl_reg;
            endcase
        end
    end

    // read data is loaded in the setup cycle so it is a flop in the access cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            case (paddr)
                OFS_CTRL:   prdata <= {29'h0, ctrl_reg};
                OFS_CFG:    prdata <= {14'h0, cfg_reg};
                OFS_PULL:   prdata <= {8'h0, pull_reg};
                OFS_GPIO:   prdata <= {16'h0, gpio_reg};
                OFS_STATUS: prdata <= {18'h0_0000, 2'(state), wake_pend, pullup_on,
                                       detach, sense, io_sync};
                OFS_POWER:  prdata <= {24'h0, power_reg};
                default:    prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // line inputs and function mapping
    // ************************************************************
    logic [LINE_W-1:0] sense_idx;
    logic [LINE_W-1:0] detach_idx;
    logic [LINE_W-1:0] wake_idx;
    logic [LINE_W-1:0] pu_idx;
    logic              detach_en;
    logic              wake_en;
    logic              ready;
    logic              ext_sel;
    logic              self_pwr;
    logic              vbus_ok;

    assign sense_idx  = cfg_reg[CFG_SENSE_LSB +: LINE_W];
    assign detach_idx = cfg_reg[CFG_DETACH_LSB +: LINE_W];
    assign wake_idx   = cfg_reg[CFG_WAKE_LSB +: LINE_W];
    assign pu_idx     = cfg_reg[CFG_PU_LSB +: LINE_W];
    assign detach_en  = cfg_reg[CFG_DETACH_EN_BIT];
    assign wake_en    = cfg_reg[CFG_WAKE_EN_BIT];
    assign ready      = ctrl_reg[CTRL_READY_BIT];
    assign ext_sel    = ctrl_reg[CTRL_EXTPU_BIT];
    assign self_pwr   = ctrl_reg[CTRL_SELFPWR_BIT];

    // raw pins are never used before the synchroniser
    prog_io_sync u_sync (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .async_in (prog_io_line_in),
        .sync_out (io_sync)
    );

    assign sense   = line_pick(io_sync, sense_idx);
    assign detach  = detach_en & line_pick(io_sync, detach_idx);
    // a bus-powered device has the supply by definition
    assign vbus_ok = ~self_pwr | sense;

    // ************************************************************
    // attach state machine
    // ************************************************************
    always_comb begin
        next_state = state;
        case (state)
            LINK_OFF: begin
                if (detach)
                    next_state = LINK_DETACHED;
                else if (ready && vbus_ok)
                    next_state = LINK_ON;
            end
            LINK_ON: begin
                if (detach)
                    next_state = LINK_DETACHED;
                else if (!ready || !vbus_ok)
                    next_state = LINK_OFF;
            end
            LINK_DETACHED: begin
                if (!detach)
                    next_state = (ready && vbus_ok) ? LINK_ON : LINK_OFF;
            end
            default: next_state = LINK_OFF;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            state <= LINK_OFF;
        else
            state <= next_state;
    end

    // pull-up follows the next state so it moves with the state flop
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pullup_on       <= 1'b0;
            dplus_pullup_en <= 1'b0;
            ext_drive       <= 1'b0;
        end else begin
            pullup_on       <= (next_state == LINK_ON);
            dplus_pullup_en <= (next_state == LINK_ON) & ~ext_sel;
            ext_drive       <= (next_state == LINK_ON) & ext_sel;
        end
    end

    // ************************************************************
    // data lines and core handshake
    // ************************************************************

    // costs one cycle of transmit latency, kept so the pad enables are flops
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            dplus_pin_out  <= 1'b0;
            dminus_pin_out <= 1'b0;
            dplus_pin_oe   <= 1'b0;
            dminus_pin_oe  <= 1'b0;
            core_rx_dp     <= 1'b0;
            core_rx_dm     <= 1'b0;
        end else begin
            dplus_pin_out  <= core_tx_dp;
            dminus_pin_out <= core_tx_dm;
            dplus_pin_oe   <= core_tx_oe & (next_state == LINK_ON);
            dminus_pin_oe  <= core_tx_oe & (next_state == LINK_ON);
            core_rx_dp     <= dplus_pin_in;
            core_rx_dm     <= dminus_pin_in;
        end
    end

    // reconnect pulse tells the core to wait for a fresh enumeration
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            core_connected   <= 1'b0;
            core_reconnect   <= 1'b0;
            core_resume_ok   <= 1'b0;
            core_bus_powered <= 1'b0;
            core_max_power   <= 8'h00;
            core_full_speed  <= 1'b0;
        end else begin
            core_connected   <= (next_state == LINK_ON);
            core_reconnect   <= (state == LINK_DETACHED) && (next_state == LINK_ON);
            // follows the next state so in-band resume stops as the link detaches
            core_resume_ok   <= core_resume_req & (next_state == LINK_ON);
            core_bus_powered <= ~self_pwr;
            core_max_power   <= power_reg;
            core_full_speed  <= FULL_SPEED_ONLY;
        end
    end

    // ************************************************************
    // host wake
    // ************************************************************

    // a request arriving as detach falls is dropped: wake is only legal detached
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            wake_pend <= 1'b0;
        else if (next_state == LINK_DETACHED && (core_resume_req || sw_wake))
            wake_pend <= 1'b1;
        else if (next_state != LINK_DETACHED)
            wake_pend <= 1'b0;
    end

    // ************************************************************
    // programmable line pads
    // ************************************************************
    logic [LINE_N-1:0] wake_mask;
    logic [LINE_N-1:0] pu_mask;

    assign wake_mask = wake_en ? line_hot(wake_idx) : '0;
    assign pu_mask   = ext_sel ? line_hot(pu_idx) : '0;

    // external pull-up line floats when off so the resistor does not pull d-plus
    prog_io_pad u_pad (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .gpio_out    (gpio_reg[LINE_N-1:0]),
        .gpio_oe     (gpio_reg[GPIO_OE_LSB +: LINE_N]),
        .ovr_mask    (wake_mask | pu_mask),
        .ovr_oe      (wake_mask | (pu_mask & {LINE_N{ext_drive}})),
        .ovr_val     ((wake_mask & {LINE_N{wake_pend}}) | (pu_mask & {LINE_N{ext_drive}})),
        .pull_up     (pull_reg[PULL_UP_LSB +: LINE_N]),
        .pull_dn     (pull_reg[PULL_DN_LSB +: LINE_N]),
        .pull_strong (pull_reg[PULL_STRONG_LSB +: LINE_N]),
        .pin_out     (prog_io_line_out),
        .pin_oe      (prog_io_line_oe),
        .pin_pu      (prog_io_line_pu),
        .pin_pd      (prog_io_line_pd),
        .pin_strong  (prog_io_line_strong)
    );

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    chk_pullup_ready: assert property (pullup_on |-> $past(ready))
        else $error("pull-up on without ready");
    chk_pullup_ext: assert property (dplus_pullup_en |-> !$past(ext_sel))
        else $error("internal pull-up on with external selected");
    chk_vbus_gate: assert property ($past(self_pwr && !sense) |-> !pullup_on)
        else $error("pull-up on with bus supply off");
    chk_sense_sync: assert property (($rose(prog_io_line_in[0]) && sense_idx == 3'h0) ##1
        (sense_idx == 3'h0) |=> sense)
        else $error("sense not seen two cycles after the pin");
    chk_wake_route: assert property ((wake_en && wake_pend) |=>
        (prog_io_line_oe[$past(wake_idx)] && prog_io_line_out[$past(wake_idx)]))
        else $error("wake not driven on its line");
    chk_detach_float: assert property ((state == LINK_DETACHED) |->
        (!dplus_pin_oe && !dminus_pin_oe && !dplus_pullup_en && !ext_drive))
        else $error("data lines driven while detached");
    chk_reconnect_seq: assert property ((state == LINK_DETACHED && next_state == LINK_ON)
        |=> (core_reconnect && pullup_on) ##1 !core_reconnect)
        else $error("reconnect not signalled once");
    chk_wake_detached: assert property (wake_pend |-> (state == LINK_DETACHED))
        else $error("host wake outside detach");
    chk_wake_cause: assert property ((next_state == LINK_DETACHED && core_resume_req)
        |=> wake_pend && !core_resume_ok)
        else $error("resume request not turned into host wake");
    chk_power_rep: assert property (##1 core_bus_powered == !$past(self_pwr))
        else $error("power mode not reported");
    chk_full_speed: assert property (rst_b |=> core_full_speed)
        else $error("full speed flag dropped");
    chk_reset_pads: assert property ($past(!rst_b) |->
        (prog_io_line_oe == 8'h00 && prog_io_line_pd == 8'hFF && !dplus_pin_oe))
        else $error("pads not in reset state");

    cov_reconnect: cover property (state == LINK_DETACHED ##1 state == LINK_ON);
    cov_wake: cover property (wake_en && $rose(wake_pend));
    cov_vbus_drop: cover property (state == LINK_ON && self_pwr && !sense);
    cov_ext_pullup: cover property ($rose(ext_drive));

endmodule : usb_attach_detach_control

/* test/usb_host_model.sv */
// host-side model resolving the usb data lines and the programmable lines
`timescale 1ns/1ps
module usb_host_model
    import usb_attach_pkg::*;
(
    input  wire logic              dplus_pin_out,
    input  wire logic              dplus_pin_oe,
    input  wire logic              dminus_pin_out,
    input  wire logic              dminus_pin_oe,
    input  wire logic              dplus_pullup_en,
    input  wire logic [LINE_N-1:0] prog_io_line_out,
    input  wire logic [LINE_N-1:0] prog_io_line_oe,
    input  wire logic [LINE_N-1:0] prog_io_line_pu,
    input  wire logic [LINE_N-1:0] drv_en,
    input  wire logic [LINE_N-1:0] drv_val,
    output logic                   dplus_pin_in,
    output logic                   dminus_pin_in,
    output logic      [LINE_N-1:0] prog_io_line_in,
    output logic                   fs_attached
);
    // ************************************************************
    // wire resolution
    // ************************************************************
    // released data lines fall to the host pull-downs; only the device pull-up lifts d-plus
    assign dplus_pin_in  = dplus_pin_oe ? dplus_pin_out : dplus_pullup_en;
    assign dminus_pin_in = dminus_pin_oe & dminus_pin_out;
    // idle d-plus high is taken as a full-speed attach, nothing faster is offered
    assign fs_attached   = dplus_pin_in & ~dminus_pin_in;
    // the embedding host drives detach and sense; other lines settle on their pulls
    assign prog_io_line_in = (prog_io_line_oe & prog_io_line_out)
                           | (~prog_io_line_oe & drv_en & drv_val)
                           | (~prog_io_line_oe & ~drv_en & prog_io_line_pu);
endmodule : usb_host_model

/* test/usb_attach_detach_control_tb.sv */
// self-checking bench for the usb attach and detach control block
`timescale 1ns/1ps
module usb_attach_detach_control_tb import usb_attach_pkg::*;;
    logic              ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rd, pv;
    logic              dplus_pin_in, dplus_pin_out, dplus_pin_oe, dplus_pullup_en, fs_attached;
    logic              dminus_pin_in, dminus_pin_out, dminus_pin_oe, core_resume_ok;
    logic              core_tx_dp, core_tx_dm, core_tx_oe, core_resume_req, core_connected;
    logic              core_reconnect, core_bus_powered, core_full_speed, core_rx_dp, core_rx_dm;
    logic [7:0]        core_max_power;
    logic [LINE_N-1:0] prog_io_line_in, prog_io_line_out, prog_io_line_oe, prog_io_line_pu;
    logic [LINE_N-1:0] prog_io_line_pd, prog_io_line_strong, drv_en, drv_val;
    int                n_mismatch, n_compared, k, di, wi;
    usb_attach_detach_control dut_u (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .prog_io_line_in, .prog_io_line_out,
        .prog_io_line_oe, .prog_io_line_pu, .prog_io_line_pd, .prog_io_line_strong,
        .dplus_pin_in, .dplus_pin_out, .dplus_pin_oe, .dminus_pin_in, .dminus_pin_out,
        .dminus_pin_oe, .dplus_pullup_en, .core_tx_dp, .core_tx_dm, .core_tx_oe,
        .core_rx_dp, .core_rx_dm, .core_resume_req, .core_resume_ok, .core_connected,
        .core_reconnect, .core_bus_powered, .core_max_power, .core_full_speed);
    usb_host_model host_u (.dplus_pin_out, .dplus_pin_oe, .dminus_pin_out, .dminus_pin_oe,
        .dplus_pullup_en, .prog_io_line_out, .prog_io_line_oe, .prog_io_line_pu, .drv_en,
        .drv_val, .dplus_pin_in, .dminus_pin_in, .prog_io_line_in, .fs_attached);
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic conclude;
        if (n_mismatch == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // pull-up wins over pull-down on a line
    function automatic logic [31:0] pull_exp(input logic [31:0] v);
        return {8'h00, v[23:16], v[7:0], v[15:8] & ~v[7:0]};
    endfunction : pull_exp
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    // apb master: request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20) begin
            n_mismatch++;
            $display("BAD %0t apb timeout", $time);
            conclude();
        end
    endtask : apb
    // bounded wait on the pull-up level, then compare
    task automatic wait_pu(input logic v);
        for (k = 0; k < 20 && dplus_pullup_en !== v; k++) cyc(1);
        chk(32'(dplus_pullup_en), 32'(v), "pullup");
    endtask : wait_pu
    // ************************************************************
    // stimulus
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        {psel, penable, pwrite, core_tx_dp, core_tx_dm, core_tx_oe, core_resume_req} = '0;
        {paddr, pwdata, drv_val} = '0;
        rst_b = 1'b0;
        n_mismatch = 0;
        n_compared = 0;
        void'($urandom(84032));
        di = 1 + $urandom % 7;
        wi = di % 7 + 1;
        drv_en = 8'h01 | (8'h01 << di);
        // reset is far shorter than the outside minimum; only the logic is under test
        cyc(6);
        chk({prog_io_line_oe, prog_io_line_pd, prog_io_line_pu, 8'h00}, 32'h00FF_0000, "rst");
        chk({dplus_pin_oe, dminus_pin_oe, dplus_pullup_en}, 32'h0, "rst usb");
        @(posedge ref_clk) rst_b <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'(CTRL_RST), "ctrl");
        apb(1'b0, OFS_CFG, 32'h0);
        chk(rd, 32'(CFG_RST), "cfg sense on line 2");
        apb(1'b0, OFS_PULL, 32'h0);
        chk(rd, 32'(PULL_RST), "pull");
        apb(1'b0, 12'h018, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000, "unmapped");
        // self powered and ready, sense low keeps the pull-up off
        apb(1'b1, OFS_CTRL, 32'h0000_0005);
        cyc(6);
        chk(32'(dplus_pullup_en), 32'h0, "no vbus");
        drv_val[0] <= 1'b1;
        wait_pu(1'b1);
        chk({fs_attached, core_full_speed, core_connected}, 32'h7, "full speed");
        core_tx_oe <= 1'b1;
        core_tx_dp <= 1'($urandom);
        apb(1'b1, OFS_CFG, 32'h0003_0000 | (wi << 8) | (di << 4));
        core_resume_req <= 1'b1;
        cyc(3);
        chk({dplus_pin_oe, dminus_pin_oe, dplus_pin_out, core_rx_dp, dminus_pin_out, core_rx_dm},
            {28'h3, core_tx_dp, core_tx_dp, 2'b00}, "tx");
        chk({core_resume_ok, prog_io_line_out[wi]}, 32'h2, "wake on");
        drv_val[di] <= 1'b1;
        wait_pu(1'b0);
        cyc(2);
        chk({dplus_pin_oe, dminus_pin_oe, core_resume_ok, core_connected}, 32'h0, "detached");
        chk(32'(prog_io_line_out[wi]), 32'h1, "wake out");
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(32'(rd[13:12]), 32'h2, "state");
        drv_val[di] <= 1'b0;
        core_resume_req <= 1'b0;
        for (k = 0; k < 20 && core_reconnect !== 1'b1; k++) cyc(1);
        chk(32'(core_reconnect), 32'h1, "reconnect");
        cyc(1);
        chk({core_reconnect, dplus_pullup_en, prog_io_line_out[wi]}, 32'h2, "back");
        // bus powered: sense no longer gates, power code handed on
        pv = $urandom;
        apb(1'b1, OFS_POWER, pv);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        drv_val[0] <= 1'b0;
        cyc(6);
        chk({dplus_pullup_en, core_bus_powered, core_max_power}, {22'h3, pv[7:0]}, "bus pw");
        pv = $urandom;
        apb(1'b1, OFS_PULL, pv);
        cyc(2);
        chk({prog_io_line_strong, prog_io_line_pu, prog_io_line_pd}, pull_exp(pv), "pulls");
        apb(1'b1, OFS_CFG, 32'h0000_5000);
        apb(1'b1, OFS_CTRL, 32'h0000_0003);
        cyc(3);
        chk({dplus_pullup_en, prog_io_line_oe[5], prog_io_line_out[5]}, 32'h3, "ext pu");
        // plain software outputs on every line but the external pull-up line
        pv = $urandom;
        apb(1'b1, OFS_GPIO, pv);
        cyc(2);
        chk({prog_io_line_oe, prog_io_line_out}, {16'h0, pv[15:8] | 8'h20, pv[7:0] | 8'h20}, "gpio");
        conclude();
    end
endmodule : usb_attach_detach_control_tb
